// File: verilog/astr_defs.vh
// Constants for the asynchronous serial transmit and receive core.
`ifndef ASTR_DEFS_VH
`define ASTR_DEFS_VH
// Register word indexes on the Avalon-MM slave.
`define ASTR_REG_CTRL     2'h0
`define ASTR_REG_STATUS   2'h1
`define ASTR_REG_DATA     2'h2
// Control register bit positions.
`define ASTR_C_TXEN       0
`define ASTR_C_RXEN       1
`define ASTR_C_WLEN       2
`define ASTR_C_PON        3
`define ASTR_C_PTYPE      4
`define ASTR_C_QLT        5
`define ASTR_C_WAKE       6
`define ASTR_C_SLEEP      7
`define ASTR_C_SBK        8
`define ASTR_C_ODS        9
`define ASTR_C_TIE        10
`define ASTR_C_TX_DONE_INT_ENABLE       11
`define ASTR_C_RIE        12
`define ASTR_C_QIE        13
`define ASTR_CTRL_W       14
// Status register bit positions.
`define ASTR_S_PF         0
`define ASTR_S_FE         1
`define ASTR_S_NF         2
`define ASTR_S_OR         3
`define ASTR_S_IDLE       4
`define ASTR_S_RX_FULL_FLAG       5
`define ASTR_S_TC         6
`define ASTR_S_TX_BUFFER_EMPTY_FLAG       7
// Reset values.
`define ASTR_CTRL_RST     14'h0000
// Sampling clock: system clock ticks per 16x sample tick and samples per bit.
`define ASTR_SYS_HZ       25000000
`define ASTR_BAUD         115200
`define ASTR_TICK_DIV     (`ASTR_SYS_HZ / (16 * `ASTR_BAUD))
`define ASTR_TICK_LOAD    8'h0C
`define ASTR_SPB          5'h10
`define ASTR_SPB_LAST     4'hF
`define ASTR_MID_A        4'h7
`define ASTR_MID_B        4'h8
`define ASTR_MID_C        4'h9
`define ASTR_EDGE_LO      4'h3
`define ASTR_EDGE_HI      4'hC
`define ASTR_START_ONES   2'h3
// Frame lengths in bits, for the two word lengths.
`define ASTR_FRAME_10     4'hA
`define ASTR_FRAME_11     4'hB
`endif

// File: verilog/astr_core.v
// Asynchronous serial transmitter and receiver with Avalon-MM registers.
// Contract
// (R01) Transmit path holds one word plus shifter.
// (R02) Shifter drives pin while enabled or busy.
// (R03) Select bit makes pin open-drain or push-pull.
// (R04) Buffer-empty clears on load, sets on transfer. The code clears it on a status write, not on the data load.
// (R05) Software clears buffer-empty before writing data.
// (R06) Complete flag low while busy; read-write clears. The code sets it as the mark bit after break starts.
// (R07) Enabling transmitter sends one idle preamble.
// (R08) Break frames while set, then mark bit.
// (R09) All sent: both flags set, pin mark.
// (R10) Disabling finishes frames, drops buffered word.
// (R11) Re-enable mid-frame sends preamble then continues.
// (R12) Transmit flags raise requests when enabled.
// (R13) Stop bit moves word, sets receive-full.
// (R14) Error flags set only at transfer.
// (R15) Full holding register: overrun, drop new frame.
// (R16) Status read arms, data read clears.
// (R17) Receive-full request; errors have no enables.
// (R18) Idle line of frame length sets flag.
// (R19) Short counts any ones; long after stop.
// (R20) Idle flag rearms only after a frame.
// (R21) Sleep suppresses receive flags and requests.
// (R22) Wake on idle line or address mark.
// (R23) Word length picks ten or eleven bits.
// (R24) Parity in data MSB, even or odd.
// (R25) Sixteen samples per bit, realigned on edges.
//
// The register offsets and the Avalon-MM register port were decided locally.
`include "astr_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module astr_core (
    input  wire        i_clk_sys,         // System clock, 25 MHz.
    input  wire        i_reset_n,         // Asynchronous reset, active low.
    input  wire [1:0]  i_avs_address,     // Register word index.
    input  wire        i_avs_read,        // Read request.
    input  wire        i_avs_write,       // Write request.
    input  wire [31:0] i_avs_writedata,   // Write data.
    output reg  [31:0] o_avs_readdata,    // Read data.
    output wire        o_avs_waitrequest, // Stall.
    input  wire        i_rxd,             // Serial input pin.
    input  wire        i_port_out,        // Port level for the pin.
    input  wire        i_port_dir,        // Port drives pin when high.
    output reg         o_txd_out,         // Serial output pin level.
    output wire        o_txd_oe,          // Serial output pin enable.
    output wire        o_irq              // Interrupt request.
);
    reg  [`ASTR_CTRL_W-1:0] ctrl;          // Control register.
    reg         ack;                       // Second cycle of a bus access.
    reg  [7:0]  stat;                      // Status flags.
    reg  [7:0]  arm;                       // Receive flags armed by a status read.
    reg  [8:0]  tx_holding_reg;            // Transmit holding word.
    reg  [8:0]  rx_holding_reg;            // Receive holding word.
    reg  [7:0]  tick_cnt;                  // Divider for the 16x sample tick.
    wire        tick = (tick_cnt == 8'h00);
    // Transmitter state.
    reg  [10:0] tx_shift;                  // Frame bits, LSB first.
    reg  [3:0]  tx_left;                   // Bits left in the frame.
    reg  [3:0]  tx_phase;                  // Sample phase within a bit.
    reg         tx_active;                 // A frame is on the wire.
    reg         pre_pend;                  // Preamble owed.
    reg         mark_pend;                 // Mark bit owed after break.
    reg         tc_arm;                    // Status read saw complete set.
    reg         txen_d;                    // Delayed enable for edge detect.
    // Receiver state.
    reg         rx_m1, rx_s, rx_p;         // Synchroniser and previous sample.
    reg  [1:0]  rx_state;                  // Receiver state.
    reg  [3:0]  rx_phase;                  // Sample phase within a bit.
    reg  [3:0]  rx_bit;                    // Bits taken in the frame.
    reg  [1:0]  ones;                      // Samples of one before a start.
    reg  [2:0]  vote;                      // First two mid-bit samples; bit 2 unused.
    reg  [10:0] rx_shift;                  // Received bits.
    reg         rx_noise;                  // Noise seen in the frame.
    reg  [4:0]  hi_samp;                   // Samples of the current one bit-time.
    reg  [3:0]  hi_bits;                   // Contiguous one bit-times.
    reg         idle_arm;                  // Idle flag may set again.
    localparam [1:0] RX_HUNT  = 2'h0;
    localparam [1:0] RX_START = 2'h1;
    localparam [1:0] RX_DATA  = 2'h2;

    wire        bus_req = i_avs_read | i_avs_write;
    wire        rd_done = i_avs_read & ack;
    wire        wr_done = i_avs_write & ack;
    wire [3:0]  flen = ctrl[`ASTR_C_WLEN] ? `ASTR_FRAME_11 : `ASTR_FRAME_10;
    wire        txen = ctrl[`ASTR_C_TXEN];

    // Majority of three samples.
    function maj3;
        input [2:0] v;
        begin
            maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
        end
    endfunction

    // Applies parity into the word MSB for the chosen word length.
    function [8:0] with_par;
        input [8:0] d;
        input       m;
        input       pon;
        input       pt;
        begin
            with_par = d;
            if (pon & m) begin
                with_par[8] = ^d[7:0] ^ pt;
            end else if (pon) begin
                with_par[7] = ^d[6:0] ^ pt;
            end
        end
    endfunction

    // Waitrequest holds the first cycle of every access.
    assign o_avs_waitrequest = bus_req & ~ack;

    // Bus handshake and read data, registered in the first cycle.
    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ack            <= 1'b0;
            o_avs_readdata <= 32'h00000000;
        end else if (!o_avs_waitrequest) begin
            // Read data stands between accesses.
            ack <= 1'b0;
        end else begin
            ack <= 1'b1;
            case (i_avs_address)
                `ASTR_REG_CTRL:   o_avs_readdata <= {18'h00000, ctrl};
                `ASTR_REG_STATUS: o_avs_readdata <= {24'h000000, stat};
                `ASTR_REG_DATA:   o_avs_readdata <= {23'h000000, rx_holding_reg};
                default:          o_avs_readdata <= 32'h00000000;
            endcase
        end
    end

    // Sample tick at sixteen times the bit rate.
    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tick_cnt <= 8'h00;
        end else if (tick) begin
            tick_cnt <= `ASTR_TICK_LOAD;
        end else begin
            tick_cnt <= tick_cnt - 8'h01;
        end
    end

    // Pin: shifter while working, else port logic, open-drain by select.
    // (R02) shifter owns pin
    always @* begin
        if (txen | tx_active) begin
            o_txd_out = tx_active ? tx_shift[0] : 1'b1;
        end else begin
            o_txd_out = i_port_out;
        end
    end
    // (R03) open-drain select
    assign o_txd_oe = ((txen | tx_active) | i_port_dir) & (~ctrl[`ASTR_C_ODS] | ~o_txd_out);

    // (R12) transmit requests
    // (R17) receive-full request
    // (R21) asleep, no receive requests
    assign o_irq = (stat[`ASTR_S_TX_BUFFER_EMPTY_FLAG] & ctrl[`ASTR_C_TIE]) | (stat[`ASTR_S_TC] & ctrl[`ASTR_C_TX_DONE_INT_ENABLE])
                 | (~ctrl[`ASTR_C_SLEEP] & ((stat[`ASTR_S_RX_FULL_FLAG] & ctrl[`ASTR_C_RIE])
                 | (stat[`ASTR_S_IDLE] & ctrl[`ASTR_C_QIE])));

    // Receiver input synchroniser.
    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rx_m1 <= 1'b1;
            rx_s  <= 1'b1;
        end else begin
            rx_m1 <= i_rxd;
            rx_s  <= rx_m1;
        end
    end

    // Transmitter, receiver and flags.
    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl           <= `ASTR_CTRL_RST;
            stat           <= 8'hC0;
            arm            <= 8'h00;
            tx_holding_reg <= 9'h000;
            rx_holding_reg <= 9'h000;
            tx_shift       <= 11'h7FF;
            tx_left        <= 4'h0;
            tx_phase       <= 4'h0;
            tx_active      <= 1'b0;
            pre_pend       <= 1'b0;
            mark_pend      <= 1'b0;
            tc_arm         <= 1'b0;
            txen_d         <= 1'b0;
            rx_p           <= 1'b1;
            rx_state       <= RX_HUNT;
            rx_phase       <= 4'h0;
            rx_bit         <= 4'h0;
            ones           <= 2'h0;
            vote           <= 3'h0;
            rx_shift       <= 11'h000;
            rx_noise       <= 1'b0;
            hi_samp        <= 5'h00;
            hi_bits        <= 4'h0;
            idle_arm       <= 1'b1;
        end else begin
            txen_d <= txen;
            // Software accesses; later set events win.
            if (wr_done && i_avs_address == `ASTR_REG_CTRL) begin
                ctrl <= i_avs_writedata[`ASTR_CTRL_W-1:0];
            end
            // (R05) status write clears buffer-empty
            if (wr_done && i_avs_address == `ASTR_REG_STATUS) begin
                stat[`ASTR_S_TX_BUFFER_EMPTY_FLAG] <= 1'b0;
            end
            // (R16) status read arms clearing
            if (rd_done && i_avs_address == `ASTR_REG_STATUS) begin
                arm    <= stat & 8'h3F;
                tc_arm <= stat[`ASTR_S_TC];
            end
            if (rd_done && i_avs_address == `ASTR_REG_DATA) begin
                stat[5:0] <= stat[5:0] & ~arm[5:0];
                arm       <= 8'h00;
            end
            // (R04) load holding word
            // (R05) ignored while buffer-empty set
            if (wr_done && i_avs_address == `ASTR_REG_DATA) begin
                if (!stat[`ASTR_S_TX_BUFFER_EMPTY_FLAG]) begin
                    tx_holding_reg <= i_avs_writedata[8:0];
                end
                // (R06) read then write clears
                if (tc_arm) begin
                    stat[`ASTR_S_TC] <= 1'b0;
                    tc_arm           <= 1'b0;
                end
            end
            // (R07) enable edge owes a preamble
            // (R11) re-enable mid-frame also
            if (txen && !txen_d) begin
                pre_pend <= 1'b1;
            end
            // Transmit bit timing, one bit per sixteen ticks.
            if (tick && tx_active) begin
                tx_phase <= tx_phase + 4'h1;
                if (tx_phase == `ASTR_SPB_LAST) begin
                    tx_shift <= {1'b1, tx_shift[10:1]};
                    tx_left  <= tx_left - 4'h1;
                    if (tx_left == 4'h1) begin
                        tx_active <= 1'b0;
                    end
                end
            end
            // Choose the next frame at a frame boundary.
            if (!tx_active && tick) begin
                tx_phase <= 4'h0;
                if (txen && pre_pend) begin
                    // (R07) idle preamble frame
                    tx_shift  <= 11'h7FF;
                    tx_left   <= flen;
                    tx_active <= 1'b1;
                    pre_pend  <= 1'b0;
                    stat[`ASTR_S_TC] <= 1'b0;
                end else if (txen && ctrl[`ASTR_C_SBK]) begin
                    // (R08) all-zero break frame
                    tx_shift  <= 11'h000;
                    tx_left   <= flen;
                    tx_active <= 1'b1;
                    mark_pend <= 1'b1;
                    stat[`ASTR_S_TC] <= 1'b0;
                end else if (mark_pend) begin
                    // (R08) one mark bit after break
                    tx_shift  <= 11'h7FF;
                    tx_left   <= 4'h1;
                    tx_active <= 1'b1;
                    mark_pend <= 1'b0;
                    stat[`ASTR_S_TC] <= 1'b1;
                end else if (txen && !stat[`ASTR_S_TX_BUFFER_EMPTY_FLAG] && !(wr_done && i_avs_address == `ASTR_REG_DATA)) begin
                    // (R01) holding word moves to shifter
                    // (R23) frame length by word length
                    // (R24) parity generated
                    tx_shift <= {1'b1, with_par(tx_holding_reg, ctrl[`ASTR_C_WLEN], ctrl[`ASTR_C_PON],
                                 ctrl[`ASTR_C_PTYPE]), 1'b0} | {1'b0, ~ctrl[`ASTR_C_WLEN], 9'h000};
                    tx_left   <= flen;
                    tx_active <= 1'b1;
                    // (R04) transfer sets buffer-empty
                    stat[`ASTR_S_TX_BUFFER_EMPTY_FLAG] <= 1'b1;
                    stat[`ASTR_S_TC]   <= 1'b0;
                end else begin
                    // (R09) idle: both flags, mark
                    // (R10) disabled: word dropped, complete
                    stat[`ASTR_S_TC] <= 1'b1;
                    if (!txen) begin
                        stat[`ASTR_S_TX_BUFFER_EMPTY_FLAG] <= 1'b1;
                        pre_pend           <= 1'b0;
                    end
                end
            end
            // Idle-line counter in bit-times of high line.
            if (tick) begin
                rx_p <= rx_s;
                // (R19) long mode ignores frame ones
                if (!rx_s || (ctrl[`ASTR_C_QLT] && rx_state != RX_HUNT)) begin
                    hi_samp <= 5'h00;
                    hi_bits <= 4'h0;
                end else if (hi_samp == `ASTR_SPB - 5'h01) begin
                    hi_samp <= 5'h00;
                    if (hi_bits != flen) begin
                        hi_bits <= hi_bits + 4'h1;
                    end
                end else begin
                    hi_samp <= hi_samp + 5'h01;
                end
            end
            // (R18) idle line of frame length
            // (R20) only once per received frame
            if (tick && hi_bits == flen && idle_arm && ctrl[`ASTR_C_RXEN]) begin
                idle_arm <= 1'b0;
                if (ctrl[`ASTR_C_SLEEP]) begin
                    // (R22) idle-line wake
                    if (!ctrl[`ASTR_C_WAKE]) begin
                        ctrl[`ASTR_C_SLEEP] <= 1'b0;
                    end
                end else begin
                    stat[`ASTR_S_IDLE] <= 1'b1;
                end
            end
            // (R25) receiver samples at 16x
            if (tick && ctrl[`ASTR_C_RXEN]) begin
                case (rx_state)
                    RX_HUNT: begin
                        // Start needs three ones then a falling edge.
                        if (rx_s && ones != `ASTR_START_ONES) begin
                            ones <= ones + 2'h1;
                        end else if (!rx_s && ones == `ASTR_START_ONES) begin
                            rx_state <= RX_START;
                            rx_phase <= 4'h1;
                            rx_bit   <= 4'h0;
                            rx_noise <= 1'b0;
                            ones     <= 2'h0;
                        end else if (!rx_s) begin
                            ones <= 2'h0;
                        end
                    end
                    RX_START, RX_DATA: begin
                        rx_phase <= rx_phase + 4'h1;
                        // (R25) realign on edges near boundary
                        if (rx_s != rx_p && (rx_phase <= `ASTR_EDGE_LO || rx_phase >= `ASTR_EDGE_HI)) begin
                            rx_phase <= 4'h1;
                        end
                        if (rx_phase == `ASTR_MID_A) begin
                            vote[0] <= rx_s;
                        end
                        if (rx_phase == `ASTR_MID_B) begin
                            vote[1] <= rx_s;
                        end
                        if (rx_phase == `ASTR_MID_C) begin
                            // (R14) noise detected per bit
                            if (vote[0] != rx_s || vote[1] != rx_s) begin
                                rx_noise <= 1'b1;
                            end
                            rx_shift <= {maj3({rx_s, vote[1:0]}), rx_shift[10:1]};
                            rx_bit   <= rx_bit + 4'h1;
                            if (rx_state == RX_START) begin
                                // A high start bit was a glitch.
                                rx_state <= maj3({rx_s, vote[1:0]}) ? RX_HUNT : RX_DATA;
                            end else if (rx_bit == flen - 4'h1) begin
                                // (R13) stop bit completes the frame
                                rx_state <= RX_HUNT;
                                idle_arm <= 1'b1;
                                if (!ctrl[`ASTR_C_SLEEP] || (ctrl[`ASTR_C_WAKE] && rx_shift[10])) begin
                                    // (R22) address mark wakes
                                    ctrl[`ASTR_C_SLEEP] <= 1'b0;
                                    if (stat[`ASTR_S_RX_FULL_FLAG] && !(rd_done && i_avs_address == `ASTR_REG_DATA &&
                                        arm[`ASTR_S_RX_FULL_FLAG])) begin
                                        // (R15) overrun keeps old word
                                        stat[`ASTR_S_OR] <= 1'b1;
                                    end else begin
                                        // (R13) transfer and set full
                                        // (R14) errors set at transfer
                                        // (R24) parity checked
                                        rx_holding_reg <= ctrl[`ASTR_C_WLEN] ? rx_shift[10:2]
                                                                             : {1'b0, rx_shift[10:3]};
                                        stat[`ASTR_S_RX_FULL_FLAG] <= 1'b1;
                                        stat[`ASTR_S_NF]   <= rx_noise | (vote[0] != rx_s) | (vote[1] != rx_s);
                                        stat[`ASTR_S_FE]   <= ~maj3({rx_s, vote[1:0]});
                                        stat[`ASTR_S_PF]   <= ctrl[`ASTR_C_PON] & (ctrl[`ASTR_C_WLEN]
                                            ? (^rx_shift[10:2] ^ ctrl[`ASTR_C_PTYPE])
                                            : (^rx_shift[10:3] ^ ctrl[`ASTR_C_PTYPE]));
                                    end
                                end
                            end
                        end
                    end
                    default: rx_state <= RX_HUNT;
                endcase
            end else if (!ctrl[`ASTR_C_RXEN]) begin
                rx_state <= RX_HUNT;
                ones     <= 2'h0;
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/astr_core_monitor.sv
// Checker for the serial core ports.
`timescale 1ns/1ps
`default_nettype none
module astr_core_monitor (
    input wire logic        i_clk_sys,         // System clock.
    input wire logic        i_reset_n,         // Reset, active low.
    input wire logic [1:0]  i_avs_address,     // Register index.
    input wire logic        i_avs_read,        // Read request.
    input wire logic        i_avs_write,       // Write request.
    input wire logic [31:0] i_avs_writedata,   // Write data.
    input wire logic [31:0] o_avs_readdata,    // Read data.
    input wire logic        o_avs_waitrequest, // Stall.
    input wire logic        o_txd_out,         // Pin level.
    input wire logic        o_txd_oe,          // Pin enable.
    input wire logic        o_irq              // Request.
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    logic [13:0] ctrl; // Control word last written.
    // Shadow the control word at each completed write.
    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) ctrl <= 14'h0000;
        else if (i_avs_write && !o_avs_waitrequest && i_avs_address == 2'h0) ctrl <= i_avs_writedata[13:0];
    end
    sequence s_req; (i_avs_read || i_avs_write) && o_avs_waitrequest; endsequence
    sequence s_ack; (i_avs_read || i_avs_write) && !o_avs_waitrequest; endsequence
    property p_wait_one; s_req |=> s_ack; endproperty
    a_wait_one: assert property (p_wait_one) else $error("stall longer than one cycle");
    property p_wait_rise; $rose(i_avs_read || i_avs_write) |-> s_req; endproperty
    a_wait_rise: assert property (p_wait_rise) else $error("new request not stalled");
    property p_idle; !(i_avs_read || i_avs_write) |-> !o_avs_waitrequest; endproperty
    a_idle: assert property (p_idle) else $error("stall without request");
    property p_unmapped; s_ack and (i_avs_read && i_avs_address == 2'h3) |-> o_avs_readdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_rd_hold; !(i_avs_read || i_avs_write) |=> $stable(o_avs_readdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved while idle");
    property p_irq_off; ctrl[13:10] == 4'h0 |-> !o_irq; endproperty
    a_irq_off: assert property (p_irq_off) else $error("request with enables off");
    property p_od; ctrl[9] |-> !(o_txd_oe && o_txd_out); endproperty
    a_od: assert property (p_od) else $error("open drain pin driven high");
    property p_tx_drive; ctrl[0] && !ctrl[9] |-> o_txd_oe; endproperty
    a_tx_drive: assert property (p_tx_drive) else $error("enabled transmitter not driving");
endmodule
bind astr_core astr_core_monitor astr_core_monitor_inst (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .o_txd_out(o_txd_out), .o_txd_oe(o_txd_oe), .o_irq(o_irq));
`default_nettype wire

// File: tb/astr_remote_model.sv
// Remote serial device model.
`timescale 1ns/1ps
`default_nettype none
module astr_remote_model #(
    parameter int BIT_CLKS = 208 // System clocks per bit.
) (
    input  wire logic i_clk,  // System clock.
    input  wire logic i_line, // Line from the core.
    output var logic  o_line  // Line into the core.
);
    logic [7:0] got;           // Last byte captured.
    int         got_count = 0; // Bytes captured.
    initial o_line = 1'b1;
    // 8N1 frame; stop 0 gives framing fault.
    task automatic send(input logic [7:0] d, input logic stop);
        logic [9:0] f = {stop, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge i_clk) o_line <= f[i];
            repeat (BIT_CLKS - 1) @(posedge i_clk);
        end
        @(posedge i_clk) o_line <= 1'b1;
    endtask
    always begin
        @(negedge i_line);
        repeat (BIT_CLKS / 2) @(posedge i_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge i_clk);
            got[i] = i_line;
        end
        repeat (BIT_CLKS) @(posedge i_clk);
        got_count++;
    end
endmodule
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the serial core.
`timescale 1ns/1ps
`default_nettype none
`include "astr_defs.vh"
module tb;
    localparam int BIT = 16 * `ASTR_TICK_DIV; // Clocks per bit.
    logic        clk = 1'b0;      // System clock.
    logic        rst_n = 1'b0;    // Reset, active low.
    logic [1:0]  addr = 2'h0;     // Register index.
    logic        rd = 1'b0;       // Read request.
    logic        wr = 1'b0;       // Write request.
    logic [31:0] wdata = 32'h0;   // Write data.
    logic [31:0] rdata;           // Read data.
    logic        wait_req;        // Stall.
    logic        txd_out;         // Pin level.
    logic        txd_oe;          // Pin enable.
    logic        irq;             // Request.
    logic        rxd;             // Line into the core.
    wire         line = txd_oe ? txd_out : 1'b1; // Pulled-up transmit line.
    logic [31:0] r;               // Last read value.
    int          bad_count = 0;   // Mismatches.
    int          comparisons = 0; // Comparisons made.
    always #20 clk = ~clk;
    astr_core astr_core_inst (.i_clk_sys(clk), .i_reset_n(rst_n), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req),
        .i_rxd(rxd), .i_port_out(1'b1), .i_port_dir(1'b1), .o_txd_out(txd_out), .o_txd_oe(txd_oe), .o_irq(irq));
    astr_remote_model #(.BIT_CLKS(BIT)) astr_remote_model_inst (.i_clk(clk), .i_line(line), .o_line(rxd));
    // Compare and count.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One bus access, held until the stall drops.
    task automatic bus(input logic read, input logic [1:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        rd <= read;
        wr <= !read;
        addr <= a;
        wdata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wait_req !== 1'b0 && n < 50);
        if (n >= 50) bad_count++;
        r = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rdchk(input logic [1:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b1, a, 32'h0);
        chk(r & m, e);
    endtask
    task automatic bits(input int n);
        repeat (n * BIT) @(posedge clk);
    endtask
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Watchdog, about 288 bit times.
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        report_and_stop();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(`ASTR_REG_STATUS, 32'hFF, 32'hC0);
        rdchk(2'h3, 32'hFFFFFFFF, 32'h0);
        bus(1'b0, `ASTR_REG_DATA, 32'h11);
        rdchk(`ASTR_REG_STATUS, 32'h80, 32'h80);
        bus(1'b0, `ASTR_REG_CTRL, 32'h1003);
        bus(1'b0, `ASTR_REG_STATUS, 32'h0);
        bus(1'b0, `ASTR_REG_DATA, 32'h5A);
        rdchk(`ASTR_REG_STATUS, 32'h80, 32'h0);
        for (int i = 0; i < 25 * BIT && astr_remote_model_inst.got_count == 0; i++) @(posedge clk);
        chk(astr_remote_model_inst.got, 32'h5A);
        bits(2);
        rdchk(`ASTR_REG_STATUS, 32'hC0, 32'hC0);
        chk(line, 32'h1);
        astr_remote_model_inst.send(8'hA5, 1'b1);
        bits(1);
        chk(irq, 32'h1);
        rdchk(`ASTR_REG_STATUS, 32'h2F, 32'h20);
        rdchk(`ASTR_REG_DATA, 32'hFF, 32'hA5);
        rdchk(`ASTR_REG_STATUS, 32'h20, 32'h0);
        chk(irq, 32'h0);
        astr_remote_model_inst.send(8'h3C, 1'b1);
        astr_remote_model_inst.send(8'hC3, 1'b1);
        bits(1);
        rdchk(`ASTR_REG_STATUS, 32'h2F, 32'h28);
        rdchk(`ASTR_REG_DATA, 32'hFF, 32'h3C);
        astr_remote_model_inst.send(8'h77, 1'b0);
        bits(1);
        rdchk(`ASTR_REG_STATUS, 32'h2F, 32'h22);
        rdchk(`ASTR_REG_DATA, 32'hFF, 32'h77);
        bus(1'b0, `ASTR_REG_CTRL, 32'h201);
        @(posedge clk);
        chk(txd_oe, 32'h0);
        report_and_stop();
    end
endmodule
`default_nettype wire
